// *** rtl/dmapr_arb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dmapr_map.svh"

module dmapr_arb import dmapr_pkg::*; (
   input  wire logic [`DMAPR_NCHAN-1:0] req_i,
   input  wire logic [`DMAPR_NCHAN-1:0] prio_i,
   output logic                         valid_o,
   output logic      [1:0]              chan_o
);

   logic [`DMAPR_NCHAN-1:0] hi_req;
   logic [`DMAPR_NCHAN-1:0] pick_set;

   // Lowest numbered channel of a set
   function automatic logic [1:0] lowest(input logic [`DMAPR_NCHAN-1:0] v);
      logic [1:0] r;
      r = 2'h0;
      for (int i = `DMAPR_NCHAN - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction

   // High priority channels win over default ones
   always_comb begin
      hi_req   = req_i & prio_i;
      pick_set = (|hi_req) ? hi_req : req_i;
      valid_o  = |req_i;
      chan_o   = lowest(pick_set);
   end

endmodule
`default_nettype wire

// *** rtl/dmapr_map.svh ***
`ifndef DMAPR_MAP_SVH
`define DMAPR_MAP_SVH

// Register byte offsets
`define DMAPR_OFS_PRIO_RAISE 12'h038
`define DMAPR_OFS_PRIO_DROP  12'h03C
`define DMAPR_OFS_FAULT      12'h04C
`define DMAPR_OFS_REQ_STATE  12'hE10
`define DMAPR_OFS_ARB_CFG    12'h100
`define DMAPR_OFS_ENG_STAT   12'h104

// Widths
`define DMAPR_ADR_W          12
`define DMAPR_NCHAN          4
`define DMAPR_EXP_W          4
`define DMAPR_CNT_W          16
`define DMAPR_ARB_W          16

// Field positions
`define DMAPR_FAULT_BIT      0
`define DMAPR_STAT_BUSY_BIT  0
`define DMAPR_STAT_CHAN_LSB  4
`define DMAPR_STAT_CNT_LSB   16

// Reset values
`define DMAPR_RST_PRIO       4'h0
`define DMAPR_RST_ARB        16'h0000
`define DMAPR_RST_CNT        16'h0000
`define DMAPR_RST_DATA       32'h0000_0000

`endif

// *** rtl/dmapr_pkg.sv ***
`include "dmapr_map.svh"

package dmapr_pkg;

   typedef enum logic [1:0] {
      DMAPR_IDLE = 2'b00,
      DMAPR_XFER = 2'b01,
      DMAPR_DONE = 2'b11
   } dmapr_fsm_t;

   typedef struct packed {
      logic [`DMAPR_NCHAN-1:0] prio;
      logic                    fault;
      logic [`DMAPR_ARB_W-1:0] arb;
      dmapr_fsm_t              fsm;
      logic [1:0]              chan;
      logic [`DMAPR_CNT_W-1:0] remain;
      logic                    ack;
      logic [31:0]             rdata;
   } dmapr_state_t;

   typedef struct packed {
      logic [`DMAPR_NCHAN-1:0] s1;
      logic [`DMAPR_NCHAN-1:0] s2;
   } dmapr_sync_state_t;

endpackage

// *** rtl/dmapr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dmapr_map.svh"

module dmapr_sync import dmapr_pkg::*; (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic [`DMAPR_NCHAN-1:0] async_i,
   output logic      [`DMAPR_NCHAN-1:0] sync_o
);

   dmapr_sync_state_t q_reg;
   dmapr_sync_state_t q_next;

   // Second stage is the only reader of the first
   always_comb begin
      q_next    = q_reg;
      q_next.s1 = async_i;
      q_next.s2 = q_reg.s1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign sync_o = q_reg.s2;

endmodule
`default_nettype wire

// *** rtl/dmapr_top.sv ***
// Function
// - Writing 1 to a channel bit of the priority-drop register returns that channel to default priority.
// - Writing 1 to bit 0 of the bus-fault register clears the bus-fault flag.
// - A new bus error in the same cycle as a clear keeps the bus-fault flag set.
// - Each request-state bit is 1 while that channel's peripheral asserts its request, else 0.
// - A pending request is served by one cycle of 2 to the power R transfers, R from the channel setting.
// - The request-state bits are read-only and are zero after reset.
// - Writing 1 to a priority-raise bit gives that channel high priority and a read returns priority state.
`timescale 1ns/1ps
`default_nettype none
`include "dmapr_map.svh"

module dmapr_top import dmapr_pkg::*; (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [`DMAPR_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   input  wire logic [`DMAPR_NCHAN-1:0] chan_req_i,
   output logic                         xfer_req_o,
   output logic      [1:0]              xfer_chan_o,
   input  wire logic                    xfer_ack_i,
   input  wire logic                    xfer_err_i,
   output logic                         cycle_busy_o
);

   dmapr_state_t            q_reg;
   dmapr_state_t            q_next;

   logic [`DMAPR_NCHAN-1:0] req_seen;
   logic                    arb_valid;
   logic [1:0]              arb_chan;

   logic                    access;
   logic                    wr_lane0;
   logic                    wr_raise;
   logic                    wr_drop;
   logic                    fault_clr;
   logic                    err_event;
   logic                    xfer_last;

   // Address compare shared by read and write decode
   function automatic logic hit(input logic [`DMAPR_ADR_W-1:0] adr,
                                input logic [`DMAPR_ADR_W-1:0] ofs);
      return adr == ofs;
   endfunction

   // Exponent field of one channel
   function automatic logic [`DMAPR_EXP_W-1:0] exp_of(input logic [`DMAPR_ARB_W-1:0] arb,
                                                      input logic [1:0]              ch);
      return arb[ch*`DMAPR_EXP_W +: `DMAPR_EXP_W];
   endfunction

   dmapr_sync u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (chan_req_i),
      .sync_o  (req_seen)
   );

   dmapr_arb u_arb (
      .req_i   (req_seen),
      .prio_i  (q_reg.prio),
      .valid_o (arb_valid),
      .chan_o  (arb_chan)
   );

   always_comb begin
      q_next    = q_reg;
      access    = wb_cyc_i & wb_stb_i & ~q_reg.ack;
      wr_lane0  = access & wb_we_i & wb_sel_i[0];
      wr_raise  = wr_lane0 & hit(wb_adr_i, `DMAPR_OFS_PRIO_RAISE);
      wr_drop   = wr_lane0 & hit(wb_adr_i, `DMAPR_OFS_PRIO_DROP);
      fault_clr = wr_lane0 & hit(wb_adr_i, `DMAPR_OFS_FAULT) & wb_dat_i[`DMAPR_FAULT_BIT];
      err_event = (q_reg.fsm == DMAPR_XFER) & xfer_ack_i & xfer_err_i;
      xfer_last = q_reg.remain == `DMAPR_CNT_W'(1);

      // Bus slave: one ack per request, dropped the next cycle
      q_next.ack   = access;
      q_next.rdata = `DMAPR_RST_DATA;

      // Priority state
      if (wr_raise) begin
         q_next.prio = q_reg.prio | wb_dat_i[`DMAPR_NCHAN-1:0];
      end else if (wr_drop) begin
         q_next.prio = q_reg.prio & ~wb_dat_i[`DMAPR_NCHAN-1:0];
      end

      // Channel transfer-count exponents
      if (access & wb_we_i & hit(wb_adr_i, `DMAPR_OFS_ARB_CFG)) begin
         if (wb_sel_i[0]) begin
            q_next.arb[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            q_next.arb[15:8] = wb_dat_i[15:8];
         end
      end

      // Error sets, clear only when no error lands
      q_next.fault = (q_reg.fault & ~fault_clr) | err_event;

      // Read mux; unmapped and write-only locations read zero
      if (access & ~wb_we_i) begin
         if (hit(wb_adr_i, `DMAPR_OFS_PRIO_RAISE)) begin
            q_next.rdata[`DMAPR_NCHAN-1:0] = q_reg.prio;
         end else if (hit(wb_adr_i, `DMAPR_OFS_FAULT)) begin
            q_next.rdata[`DMAPR_FAULT_BIT] = q_reg.fault;
         end else if (hit(wb_adr_i, `DMAPR_OFS_REQ_STATE)) begin
            q_next.rdata[`DMAPR_NCHAN-1:0] = req_seen;
         end else if (hit(wb_adr_i, `DMAPR_OFS_ARB_CFG)) begin
            q_next.rdata[`DMAPR_ARB_W-1:0] = q_reg.arb;
         end else if (hit(wb_adr_i, `DMAPR_OFS_ENG_STAT)) begin
            q_next.rdata[`DMAPR_STAT_BUSY_BIT] = q_reg.fsm != DMAPR_IDLE;
            q_next.rdata[`DMAPR_STAT_CHAN_LSB +: 2] = q_reg.chan;
            q_next.rdata[`DMAPR_STAT_CNT_LSB +: `DMAPR_CNT_W] = q_reg.remain;
         end
      end

      // Transfer engine
      case (q_reg.fsm)
         DMAPR_IDLE: begin
            if (arb_valid) begin
               q_next.chan   = arb_chan;
               q_next.remain = `DMAPR_CNT_W'(1) << exp_of(q_reg.arb, arb_chan);
               q_next.fsm    = DMAPR_XFER;
            end
         end
         DMAPR_XFER: begin
            if (xfer_ack_i) begin
               q_next.remain = q_reg.remain - `DMAPR_CNT_W'(1);
               // An error response ends the cycle early
               if (xfer_err_i | xfer_last) begin
                  q_next.fsm = DMAPR_DONE;
               end
            end
         end
         DMAPR_DONE: begin
            q_next.fsm = DMAPR_IDLE;
         end
         default: begin
            q_next.fsm = DMAPR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_reg.prio   <= `DMAPR_RST_PRIO;
         q_reg.fault  <= 1'b0;
         q_reg.arb    <= `DMAPR_RST_ARB;
         q_reg.fsm    <= DMAPR_IDLE;
         q_reg.chan   <= 2'h0;
         q_reg.remain <= `DMAPR_RST_CNT;
         q_reg.ack    <= 1'b0;
         q_reg.rdata  <= `DMAPR_RST_DATA;
      end else begin
         q_reg <= q_next;
      end
   end

   assign wb_ack_o     = q_reg.ack;
   assign wb_dat_o     = q_reg.rdata;
   assign xfer_req_o   = q_reg.fsm == DMAPR_XFER;
   assign xfer_chan_o  = q_reg.chan;
   assign cycle_busy_o = q_reg.fsm != DMAPR_IDLE;

   // Checks

   property p_prio_drop;
      @(posedge clk_i) disable iff (rst_i)
      wr_drop |=> (q_reg.prio & $past(wb_dat_i[3:0])) == 4'h0;
   endproperty
   a_prio_drop: assert property (p_prio_drop) else $error("priority drop ignored");

   property p_prio_raise;
      @(posedge clk_i) disable iff (rst_i)
      wr_raise |=> (q_reg.prio & $past(wb_dat_i[3:0])) == $past(wb_dat_i[3:0]);
   endproperty
   a_prio_raise: assert property (p_prio_raise) else $error("priority raise ignored");

   property p_fault_clear;
      @(posedge clk_i) disable iff (rst_i)
      (fault_clr && !err_event) |=> !q_reg.fault ##1 (wb_ack_o || !q_reg.fault || $past(err_event));
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("fault flag not cleared");

   property p_fault_wins;
      @(posedge clk_i) disable iff (rst_i)
      (err_event && fault_clr) |=> q_reg.fault;
   endproperty
   a_fault_wins: assert property (p_fault_wins) else $error("clear beat a new error");

   property p_fault_sticky;
      @(posedge clk_i) disable iff (rst_i)
      (err_event || (q_reg.fault && !fault_clr)) |=> q_reg.fault;
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag lost");

   property p_req_state;
      @(posedge clk_i) disable iff (rst_i)
      (!$past(rst_i) && !$past(rst_i, 2)) |-> req_seen == $past(chan_req_i, 2);
   endproperty
   a_req_state: assert property (p_req_state) else $error("request state not tracking pins");

   property p_cycle_len;
      @(posedge clk_i) disable iff (rst_i)
      (q_reg.fsm == DMAPR_XFER && $past(q_reg.fsm) == DMAPR_IDLE)
         |-> q_reg.remain == (`DMAPR_CNT_W'(1) << exp_of(q_reg.arb, q_reg.chan));
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("cycle length not a power of two");

   property p_cycle_end;
      @(posedge clk_i) disable iff (rst_i)
      (xfer_req_o && xfer_ack_i && xfer_last) |=> q_reg.fsm == DMAPR_DONE ##1 q_reg.fsm == DMAPR_IDLE;
   endproperty
   a_cycle_end: assert property (p_cycle_end) else $error("cycle did not end on last transfer");

   property p_req_reset;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> req_seen == 4'h0;
   endproperty
   a_req_reset: assert property (p_req_reset) else $error("request state not zero after reset");

   property p_ack_answer;
      @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered");

   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held beyond one cycle");

   property p_rdata_idle;
      @(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ack cycle");

   property p_req_read;
      @(posedge clk_i) disable iff (rst_i)
      (access && !wb_we_i && hit(wb_adr_i, `DMAPR_OFS_REQ_STATE))
         |=> wb_dat_o == {28'h0, $past(req_seen)};
   endproperty
   a_req_read: assert property (p_req_read) else $error("request state read wrong");

   property p_prio_drop_keep;
      @(posedge clk_i) disable iff (rst_i)
      wr_drop |=> q_reg.prio == ($past(q_reg.prio) & ~$past(wb_dat_i[3:0]));
   endproperty
   a_prio_drop_keep: assert property (p_prio_drop_keep) else $error("priority drop touched other channels");

   property p_prio_hold;
      @(posedge clk_i) disable iff (rst_i)
      !(wr_raise || wr_drop) |=> $stable(q_reg.prio);
   endproperty
   a_prio_hold: assert property (p_prio_hold) else $error("priority changed without a write");

   property p_fault_read;
      @(posedge clk_i) disable iff (rst_i)
      (access && !wb_we_i && hit(wb_adr_i, `DMAPR_OFS_FAULT))
         |=> wb_dat_o == {31'h0, $past(q_reg.fault)};
   endproperty
   a_fault_read: assert property (p_fault_read) else $error("fault flag read wrong");

   property p_fault_hold;
      @(posedge clk_i) disable iff (rst_i)
      (!err_event && !fault_clr) |=> q_reg.fault == $past(q_reg.fault);
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault flag changed on its own");

   property p_xfer_step;
      @(posedge clk_i) disable iff (rst_i)
      (xfer_req_o && xfer_ack_i && !xfer_err_i && !xfer_last)
         |=> xfer_req_o && q_reg.remain == $past(q_reg.remain) - 16'h0001;
   endproperty
   a_xfer_step: assert property (p_xfer_step) else $error("transfer not counted");

   property p_err_ends;
      @(posedge clk_i) disable iff (rst_i)
      (xfer_req_o && xfer_ack_i && xfer_err_i) |=> !xfer_req_o && q_reg.fault;
   endproperty
   a_err_ends: assert property (p_err_ends) else $error("error response not handled");

   property p_start_on_req;
      @(posedge clk_i) disable iff (rst_i)
      (q_reg.fsm == DMAPR_IDLE && req_seen != 4'h0)
         |=> xfer_req_o && (($past(req_seen) >> xfer_chan_o) & 4'h1) == 4'h1;
   endproperty
   a_start_on_req: assert property (p_start_on_req) else $error("pending request not served");

   property p_prio_first;
      @(posedge clk_i) disable iff (rst_i)
      (q_reg.fsm == DMAPR_IDLE && (req_seen & q_reg.prio) != 4'h0)
         |=> (($past(q_reg.prio) >> xfer_chan_o) & 4'h1) == 4'h1;
   endproperty
   a_prio_first: assert property (p_prio_first) else $error("high priority channel passed over");

   property p_no_start;
      @(posedge clk_i) disable iff (rst_i)
      (q_reg.fsm == DMAPR_IDLE && req_seen == 4'h0) |=> !xfer_req_o;
   endproperty
   a_no_start: assert property (p_no_start) else $error("cycle started with no request");

endmodule
`default_nettype wire

// *** verification/dmapr_periph.sv ***
`timescale 1ns/1ps
`default_nettype none

module dmapr_periph import dmapr_pkg::*; (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [3:0] req_set_i,
   input  wire logic [3:0] wait_i,
   input  wire logic       err_i,
   input  wire logic       xfer_req_i,
   output logic      [3:0] chan_req_o,
   output logic            xfer_ack_o,
   output logic            xfer_err_o
);
   logic [3:0] cnt_reg;

   assign chan_req_o = req_set_i;
   // Error line shows junk outside a completion
   assign xfer_err_o = xfer_ack_o ? err_i : ~err_i;

   // One completion after wait_i + 1 idle cycles, then a gap
   always_ff @(posedge clk_i) begin
      if (rst_i || !xfer_req_i || xfer_ack_o) begin
         cnt_reg    <= 4'h0;
         xfer_ack_o <= 1'b0;
      end else if (cnt_reg == wait_i) begin
         xfer_ack_o <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dmapr_map.svh"

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module tb_top import dmapr_pkg::*;;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, err = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic [3:0]  req = 4'h0, wt = 4'h0, chan_req;
   logic        ack, xreq, xack, xerr, busy;
   logic [1:0]  xchan;
   int          n_mismatch = 0, num_checks = 0, cyc_cnt = 0, n;

   always #12.5 clk_i = ~clk_i;

   dmapr_top dmapr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .chan_req_i(chan_req), .xfer_req_o(xreq), .xfer_chan_o(xchan),
      .xfer_ack_i(xack), .xfer_err_i(xerr), .cycle_busy_o(busy));

   dmapr_periph dmapr_periph_inst (.clk_i(clk_i), .rst_i(rst_i), .req_set_i(req), .wait_i(wt),
      .err_i(err), .xfer_req_i(xreq), .chan_req_o(chan_req), .xfer_ack_o(xack), .xfer_err_o(xerr));

   task automatic tally_and_finish();
      $display("mismatches %0d checks %0d", n_mismatch, num_checks);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   // Classic cycle, held until ack seen
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask

   task automatic t_reset();
      rd_chk(`DMAPR_OFS_REQ_STATE, 32'h0);
      rd_chk(`DMAPR_OFS_PRIO_RAISE, 32'h0);
      rd_chk(`DMAPR_OFS_FAULT, 32'h0);
      rd_chk(12'h200, 32'h0);
   endtask

   task automatic t_prio();
      wb(1'b1, `DMAPR_OFS_PRIO_RAISE, 32'h0000_000F);
      rd_chk(`DMAPR_OFS_PRIO_RAISE, 32'h0000_000F);
      rd_chk(`DMAPR_OFS_PRIO_DROP, 32'h0);
      wb(1'b1, `DMAPR_OFS_PRIO_DROP, 32'h0000_0005);
      rd_chk(`DMAPR_OFS_PRIO_RAISE, 32'h0000_000A);
      wb(1'b1, `DMAPR_OFS_PRIO_DROP, 32'h0000_000A);
      rd_chk(`DMAPR_OFS_PRIO_RAISE, 32'h0000_0000);
   endtask

   task automatic t_req_state();
      @(posedge clk_i) req <= 4'hA;
      repeat (4) @(posedge clk_i);
      rd_chk(`DMAPR_OFS_REQ_STATE, 32'h0000_000A);
      wb(1'b1, `DMAPR_OFS_REQ_STATE, 32'h0000_000F);
      rd_chk(`DMAPR_OFS_REQ_STATE, 32'h0000_000A);
      @(posedge clk_i) req <= 4'h0;
      repeat (40) @(posedge clk_i);
      rd_chk(`DMAPR_OFS_REQ_STATE, 32'h0);
   endtask

   // Exponent 2 on channel 2 with a slow partner
   task automatic t_burst();
      wb(1'b1, `DMAPR_OFS_ARB_CFG, 32'h0000_0200);
      @(posedge clk_i) begin
         wt  <= 4'h3;
         req <= 4'h4;
      end
      do @(negedge clk_i); while (xreq !== 1'b1);
      `CHK(xchan, 2'h2)
      @(posedge clk_i) req <= 4'h0;
      n = 0;
      repeat (200) begin
         @(negedge clk_i);
         if (xreq === 1'b1 && xack === 1'b1) n++;
      end
      `CHK(n, 4)
      `CHK(busy, 1'b0)
      rd_chk(`DMAPR_OFS_ARB_CFG, 32'h0000_0200);
      rd_chk(`DMAPR_OFS_ENG_STAT, 32'h0000_0020);
   endtask

   // High priority channel beats a lower index until dropped
   task automatic t_arb();
      wb(1'b1, `DMAPR_OFS_PRIO_RAISE, 32'h0000_0008);
      @(posedge clk_i) begin
         wt  <= 4'h0;
         req <= 4'hA;
      end
      do @(negedge clk_i); while (xreq !== 1'b1);
      `CHK(xchan, 2'h3)
      @(posedge clk_i) req <= 4'h0;
      repeat (10) @(posedge clk_i);
      wb(1'b1, `DMAPR_OFS_PRIO_DROP, 32'h0000_0008);
      @(posedge clk_i) req <= 4'hA;
      do @(negedge clk_i); while (xreq !== 1'b1);
      `CHK(xchan, 2'h1)
      @(posedge clk_i) req <= 4'h0;
      repeat (10) @(posedge clk_i);
      `CHK(busy, 1'b0)
   endtask

   // Error completion, with a clear in the same edge when clr is set
   task automatic t_fault(input logic clr);
      @(posedge clk_i) begin
         wt  <= 4'h1;
         err <= 1'b1;
         req <= 4'h2;
      end
      do @(negedge clk_i); while (xreq !== 1'b1);
      @(posedge clk_i) req <= 4'h0;
      if (clr) wb(1'b1, `DMAPR_OFS_FAULT, 32'h0000_0001);
      repeat (6) @(posedge clk_i);
      rd_chk(`DMAPR_OFS_FAULT, 32'h0000_0001);
      @(posedge clk_i) err <= 1'b0;
      wb(1'b1, `DMAPR_OFS_FAULT, 32'h0000_0001);
      rd_chk(`DMAPR_OFS_FAULT, 32'h0);
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_prio();
      t_req_state();
      t_burst();
      t_fault(1'b0);
      t_fault(1'b1);
      t_arb();
      tally_and_finish();
   end
endmodule

`default_nettype wire
